// *** hw/ctm_pkg.sv ***
// Shared constants of the charger thermal monitor and serial port.
package ctm_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h6b;
  localparam int CLK_HZ = 20000000;
  localparam int WINDOW_MS = 25;
  localparam int PERIOD_MS = 225;
  localparam int IRQ_PULSE_US = 128;
  localparam int WINDOW_CYC = WINDOW_MS * (CLK_HZ / 1000);
  localparam int PERIOD_CYC = PERIOD_MS * (CLK_HZ / 1000);
  localparam int IRQ_CYC = IRQ_PULSE_US * (CLK_HZ / 1000000);
  localparam logic [7:0] ADDR_FAULT = 8'h00;
  localparam logic [7:0] ADDR_TS_MSB = 8'h01;
  localparam logic [7:0] ADDR_SLOT = 8'h02;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h03;
  localparam logic [7:0] ADDR_THERM_CTRL = 8'h04;
  localparam logic [7:0] ADDR_REDUCED_V = 8'h05;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'h06;
  localparam logic [7:0] ADDR_COLD = 8'h07;
  localparam logic [7:0] ADDR_COOL = 8'h08;
  localparam logic [7:0] ADDR_WARM = 8'h09;
  localparam logic [7:0] ADDR_HOT = 8'h0a;
  localparam logic [7:0] ADDR_OPEN = 8'h0b;
  localparam logic [7:0] UNMAPPED_DATA = 8'hff;
  localparam logic [7:0] COLD_RST = 8'h7c;
  localparam logic [7:0] COOL_RST = 8'h6d;
  localparam logic [7:0] WARM_RST = 8'h38;
  localparam logic [7:0] HOT_RST = 8'h27;
  localparam logic [7:0] OPEN_RST = 8'hc0;
  localparam logic [7:0] PIN_CTRL_RST = 8'h04;
  localparam logic [7:0] THERM_CTRL_RST = 8'h00;
  localparam logic [7:0] REDUCED_V_RST = 8'h00;
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  localparam int FLT_HOT = 0;
  localparam int FLT_WARM = 1;
  localparam int FLT_COOL = 2;
  localparam int FLT_COLD = 3;
  localparam int FLT_OPEN = 4;
  localparam int PIN_DRIVE_BIT = 2;
  localparam int SCALE_LSB = 2;
  localparam int AUX_EN_BIT = 0;
  localparam int AUX_SLOT_BIT = 1;
  localparam logic [1:0] PROFILE_FOUR = 2'h0;
  localparam logic [1:0] PROFILE_HOTCOLD = 2'h1;
  localparam logic [1:0] PIN_MODE_SUPPLY = 2'h0;
  localparam logic [1:0] PIN_MODE_BUTTON = 2'h1;
endpackage : ctm_pkg

// *** hw/ctm_sync.sv ***
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ctm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Each bit follows only when the two later stages agree.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule : ctm_sync
`default_nettype wire

// *** hw/ctm_top.sv ***
// Charger status pin, thermistor monitor and serial target port.
// Functional notes
// - Default mode: pull pin low when supply valid.
// - Mode 01: pin mirrors pushbutton input.
// - Mode 1x: pin follows drive value bit.
// - Bias 25ms every 225ms while supply present.
// - Profile: four-threshold, hot/cold, or disabled.
// - Hot or cold suspends charge and timer.
// - Cool zone scales current, rounding down.
// - Warm zone lowers regulation voltage.
// - Any fault gives 128us interrupt pulse.
// - Fault bits stay until read.
// - Interrupt on every threshold crossing.
// - Open thermistor disables charging.
// - Default thresholds match documented voltages.
// - Limits compare against result upper byte.
// - Aux input biased like thermistor, readable.
// - Target only, standard and fast mode.
// - Answers to seven-bit address 6Bh.
// - Acknowledge only on address match.
// - Nine-bit units, receiver acknowledges.
// - Unmapped reads return FFh.
// - Registers kept while any supply is up.
`timescale 1ns/1ps
`default_nettype none
module ctm_top #(
  parameter int WINDOW_CYCLES = ctm_pkg::WINDOW_CYC,
  parameter int PERIOD_CYCLES = ctm_pkg::PERIOD_CYC,
  parameter int RESULT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic in_above_lockout,
  input wire logic in_above_sleep,
  input wire logic in_below_ovp,
  input wire logic pushbutton_input,
  output logic status_pin_o,
  output logic status_pin_oe_n,
  output logic int_o,
  output logic int_oe_n,
  output logic ts_bias_en,
  output logic aux_bias_en,
  input wire logic [RESULT_W-1:0] ts_result,
  input wire logic ts_result_valid,
  input wire logic [RESULT_W-1:0] aux_result,
  input wire logic aux_result_valid,
  input wire logic [7:0] fast_charge_current,
  output logic [7:0] charge_current_code,
  output logic charge_suspend,
  output logic safety_timer_halt,
  output logic charge_disable,
  output logic battery_regulation_reduce,
  output logic [7:0] reduced_voltage_code
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [5:0] pins_s;
  logic scl;
  logic sda;
  logic in_ok_lockout;
  logic in_ok_sleep;
  logic in_ok_ovp;
  logic button;
  logic scl_d;
  logic sda_d;

  ctm_sync #(.W(6), .RST_VAL(6'h23)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({pushbutton_input, in_below_ovp, in_above_sleep, in_above_lockout, sda_in, scl_in}),
    .q(pins_s)
  );

  assign scl = pins_s[0];
  assign sda = pins_s[1];
  assign in_ok_lockout = pins_s[2];
  assign in_ok_sleep = pins_s[3];
  assign in_ok_ovp = pins_s[4];
  assign button = pins_s[5];

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_cond = scl & scl_d & sda_d & ~sda;
  assign stop_cond = scl & scl_d & ~sda_d & sda;

  ////////////////////////////////////////////////////////////////////////////
  // Registers, kept until srst, which only rises when both supplies are lost.
  logic [7:0] pin_ctrl;
  logic [7:0] therm_ctrl;
  logic [7:0] reduced_v;
  logic [7:0] aux_ctrl;
  logic [7:0] cold_limit;
  logic [7:0] cool_limit;
  logic [7:0] warm_limit;
  logic [7:0] hot_limit;
  logic [7:0] open_limit;
  logic [4:0] fault_flags;
  logic [7:0] ts_msb;
  logic [7:0] aux_msb;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_clear;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_ctrl <= ctm_pkg::PIN_CTRL_RST;
      therm_ctrl <= ctm_pkg::THERM_CTRL_RST;
      reduced_v <= ctm_pkg::REDUCED_V_RST;
      aux_ctrl <= ctm_pkg::AUX_CTRL_RST;
      cold_limit <= ctm_pkg::COLD_RST;
      cool_limit <= ctm_pkg::COOL_RST;
      warm_limit <= ctm_pkg::WARM_RST;
      hot_limit <= ctm_pkg::HOT_RST;
      open_limit <= ctm_pkg::OPEN_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        ctm_pkg::ADDR_PIN_CTRL: pin_ctrl <= wr_data;
        ctm_pkg::ADDR_THERM_CTRL: therm_ctrl <= wr_data;
        ctm_pkg::ADDR_REDUCED_V: reduced_v <= wr_data;
        ctm_pkg::ADDR_AUX_CTRL: aux_ctrl <= wr_data;
        ctm_pkg::ADDR_COLD: cold_limit <= wr_data;
        ctm_pkg::ADDR_COOL: cool_limit <= wr_data;
        ctm_pkg::ADDR_WARM: warm_limit <= wr_data;
        ctm_pkg::ADDR_HOT: hot_limit <= wr_data;
        ctm_pkg::ADDR_OPEN: open_limit <= wr_data;
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] r;
    r = ctm_pkg::UNMAPPED_DATA;
    unique case (a)
      ctm_pkg::ADDR_FAULT: r = {3'h0, fault_flags};
      ctm_pkg::ADDR_TS_MSB: r = ts_msb;
      ctm_pkg::ADDR_SLOT: r = aux_ctrl[ctm_pkg::AUX_SLOT_BIT] ? aux_msb : ts_msb;
      ctm_pkg::ADDR_PIN_CTRL: r = pin_ctrl;
      ctm_pkg::ADDR_THERM_CTRL: r = therm_ctrl;
      ctm_pkg::ADDR_REDUCED_V: r = reduced_v;
      ctm_pkg::ADDR_AUX_CTRL: r = aux_ctrl;
      ctm_pkg::ADDR_COLD: r = cold_limit;
      ctm_pkg::ADDR_COOL: r = cool_limit;
      ctm_pkg::ADDR_WARM: r = warm_limit;
      ctm_pkg::ADDR_HOT: r = hot_limit;
      ctm_pkg::ADDR_OPEN: r = open_limit;
      default: ;
    endcase
    return r;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // Serial target port.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR = 7'h08,
    ST_WR_ACK = 7'h10,
    ST_RD = 7'h20,
    ST_RD_ACK = 7'h40
  } ctm_state_t;

  ctm_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic ptr_phase;
  logic rw_bit;
  logic host_ack;
  logic sda_low;
  logic [7:0] rd_byte;

  // Byte that a read would load from the current pointer.
  always_comb begin
    rd_byte = read_mux(ptr);
  end

  always_ff @(posedge clk) begin
    wr_en <= 1'b0;
    rd_clear <= 1'b0;
    if (srst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      ptr_phase <= 1'b0;
      rw_bit <= 1'b0;
      host_ack <= 1'b0;
      sda_low <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_WR || state == ST_RD) begin
        shreg <= {shreg[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (state == ST_RD_ACK) begin
        host_ack <= ~sda;
      end
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == ctm_pkg::TARGET_ADDR) begin
              state <= ST_ADDR_ACK;
              rw_bit <= shreg[0];
              sda_low <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (rw_bit) begin
            state <= ST_RD;
            txreg <= rd_byte;
            sda_low <= ~rd_byte[7];
            rd_clear <= (ptr == ctm_pkg::ADDR_FAULT);
          end else begin
            state <= ST_WR;
            ptr_phase <= 1'b1;
            sda_low <= 1'b0;
          end
        end
        ST_WR: begin
          if (bit_cnt == 4'h8) begin
            state <= ST_WR_ACK;
            sda_low <= 1'b1;
            if (ptr_phase) begin
              ptr <= shreg;
              ptr_phase <= 1'b0;
            end else begin
              wr_en <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
            end
          end
        end
        ST_WR_ACK: begin
          state <= ST_WR;
          bit_cnt <= 4'h0;
          sda_low <= 1'b0;
        end
        ST_RD: begin
          if (bit_cnt == 4'h8) begin
            state <= ST_RD_ACK;
            sda_low <= 1'b0;
            ptr <= ptr + 8'h01;
          end else begin
            txreg <= {txreg[6:0], 1'b0};
            sda_low <= ~txreg[6];
          end
        end
        ST_RD_ACK: begin
          bit_cnt <= 4'h0;
          if (host_ack) begin
            state <= ST_RD;
            txreg <= rd_byte;
            sda_low <= ~rd_byte[7];
            rd_clear <= (ptr == ctm_pkg::ADDR_FAULT);
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // Status pin.
  logic pin_low;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_low <= 1'b0;
    end else if (pin_ctrl[1]) begin
      pin_low <= ~pin_ctrl[ctm_pkg::PIN_DRIVE_BIT];
    end else if (pin_ctrl[1:0] == ctm_pkg::PIN_MODE_BUTTON) begin
      pin_low <= ~button;
    end else begin
      pin_low <= in_ok_lockout & in_ok_sleep & in_ok_ovp;
    end
  end
  assign status_pin_o = 1'b0;
  assign status_pin_oe_n = ~pin_low;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling windows.
  logic [31:0] samp_cnt;
  logic window;
  always_ff @(posedge clk) begin
    if (srst || !in_ok_lockout) begin
      samp_cnt <= 32'h0;
    end else if (samp_cnt == 32'(PERIOD_CYCLES - 1)) begin
      samp_cnt <= 32'h0;
    end else begin
      samp_cnt <= samp_cnt + 32'h1;
    end
  end
  assign window = in_ok_lockout && (samp_cnt < 32'(WINDOW_CYCLES));

  always_ff @(posedge clk) begin
    if (srst) begin
      ts_bias_en <= 1'b0;
      aux_bias_en <= 1'b0;
    end else begin
      ts_bias_en <= window;
      aux_bias_en <= window & aux_ctrl[ctm_pkg::AUX_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ts_msb <= 8'h00;
      aux_msb <= 8'h00;
    end else begin
      if (ts_result_valid && ts_bias_en) begin
        ts_msb <= ts_result[RESULT_W-1 -: 8];
      end
      if (aux_result_valid && aux_bias_en) begin
        aux_msb <= aux_result[RESULT_W-1 -: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zones, faults and interrupt pulse.
  logic [4:0] zone;
  logic [4:0] next_zone;
  logic [11:0] irq_cnt;
  always_comb begin
    next_zone = 5'h0;
    next_zone[ctm_pkg::FLT_HOT] = ts_msb < hot_limit;
    next_zone[ctm_pkg::FLT_WARM] = (ts_msb > hot_limit) && (ts_msb < warm_limit);
    next_zone[ctm_pkg::FLT_COOL] = (ts_msb > cool_limit) && (ts_msb < cold_limit);
    next_zone[ctm_pkg::FLT_COLD] = ts_msb > cold_limit;
    next_zone[ctm_pkg::FLT_OPEN] = ts_msb > open_limit;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zone <= 5'h0;
    end else begin
      zone <= next_zone;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_flags <= 5'h0;
    end else begin
      fault_flags <= (fault_flags & ~{5{rd_clear}}) | (next_zone & ~zone);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_cnt <= 12'h0;
    end else if (next_zone != zone) begin
      irq_cnt <= 12'(ctm_pkg::IRQ_CYC);
    end else if (irq_cnt != 12'h0) begin
      irq_cnt <= irq_cnt - 12'h1;
    end
  end
  assign int_o = 1'b0;
  assign int_oe_n = (irq_cnt == 12'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Charge control.
  logic [1:0] profile;
  logic [2:0] scale;
  logic [10:0] scaled;
  assign profile = therm_ctrl[1:0];
  assign scale = therm_ctrl[ctm_pkg::SCALE_LSB +: 3];
  assign scaled = (11'(fast_charge_current) * 11'(4'h8 - {1'b0, scale})) >> 3;

  always_ff @(posedge clk) begin
    if (srst) begin
      charge_suspend <= 1'b0;
      safety_timer_halt <= 1'b0;
      charge_disable <= 1'b0;
      battery_regulation_reduce <= 1'b0;
      charge_current_code <= 8'h00;
      reduced_voltage_code <= ctm_pkg::REDUCED_V_RST;
    end else begin
      charge_suspend <= 1'b0;
      safety_timer_halt <= 1'b0;
      battery_regulation_reduce <= 1'b0;
      charge_current_code <= fast_charge_current;
      reduced_voltage_code <= reduced_v;
      charge_disable <= zone[ctm_pkg::FLT_OPEN];
      if (profile == ctm_pkg::PROFILE_FOUR || profile == ctm_pkg::PROFILE_HOTCOLD) begin
        if (zone[ctm_pkg::FLT_HOT] || zone[ctm_pkg::FLT_COLD]) begin
          charge_suspend <= 1'b1;
          safety_timer_halt <= 1'b1;
        end
      end
      if (profile == ctm_pkg::PROFILE_FOUR) begin
        if (zone[ctm_pkg::FLT_COOL]) begin
          charge_current_code <= scaled[7:0];
        end
        battery_regulation_reduce <= zone[ctm_pkg::FLT_WARM];
      end
    end
  end
endmodule : ctm_top
`default_nettype wire

// *** verification/ctm_properties.sv ***
// Concurrent checks on the pins of the charger thermal monitor and serial port.
`timescale 1ns/1ps
`default_nettype none
module ctm_chk #(
  parameter int WINDOW_CYCLES = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic in_above_lockout,
  input wire logic int_oe_n,
  input wire logic ts_bias_en,
  input wire logic [7:0] fast_charge_current,
  input wire logic [7:0] charge_current_code,
  input wire logic charge_suspend,
  input wire logic safety_timer_halt,
  input wire logic charge_disable,
  input wire logic battery_regulation_reduce
);
  int low_cnt;
  int hi_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  always_ff @(posedge clk) begin
    low_cnt <= (srst || int_oe_n) ? 0 : low_cnt + 1;
  end
  always_ff @(posedge clk) begin
    hi_cnt <= (srst || !ts_bias_en) ? 0 : hi_cnt + 1;
  end
  sequence s_zone_entry;
    $rose(charge_suspend) || $rose(charge_disable) || $rose(battery_regulation_reduce);
  endsequence
  sequence s_stop_seen;
    scl_in && $rose(sda_in) && sda_oe_n;
  endsequence
  AST_INT_PULSE: assert property ($rose(int_oe_n) |-> low_cnt >= ctm_pkg::IRQ_CYC)
    else $error("interrupt pulse too short");
  AST_BIAS_WIN: assert property (ts_bias_en |-> hi_cnt < WINDOW_CYCLES)
    else $error("bias window too long");
  AST_BIAS_OFF: assert property (!in_above_lockout [*8] |-> !ts_bias_en)
    else $error("bias on without input supply");
  AST_SDA_EDGE: assert property (!$stable(sda_oe_n) |-> !scl_in)
    else $error("data line changed while clock high");
  AST_SUSP_HALT: assert property (charge_suspend |-> safety_timer_halt)
    else $error("charge suspended with timer running");
  AST_SCALE_MAX: assert property (charge_current_code <= $past(fast_charge_current))
    else $error("charge current above programmed value");
  AST_ZONE_INT: assert property (s_zone_entry |-> !int_oe_n)
    else $error("zone change without interrupt");
  AST_STOP_IDLE: assert property (s_stop_seen |=> sda_oe_n [*8])
    else $error("data line driven after stop");
endmodule : ctm_chk
bind ctm_top ctm_chk #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .in_above_lockout(in_above_lockout), .int_oe_n(int_oe_n), .ts_bias_en(ts_bias_en),
  .fast_charge_current(fast_charge_current), .charge_current_code(charge_current_code),
  .charge_suspend(charge_suspend), .safety_timer_halt(safety_timer_halt),
  .charge_disable(charge_disable), .battery_regulation_reduce(battery_regulation_reduce));
`default_nettype wire

// *** verification/ctm_host.sv ***
// Bus controller model that drives the serial clock and pulls the data line.
`timescale 1ns/1ps
`default_nettype none
module ctm_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int QC = 13;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  task automatic q();
    repeat (QC) @(negedge clk);
  endtask : q
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task automatic wr(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack_n);
  endtask : wr
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask : rd
endmodule : ctm_host
`default_nettype wire

// *** verification/tb_charger_thermal_monitor_i2c_port.sv ***
// Self-checking bench for the charger thermal monitor and serial port.
`timescale 1ns/1ps
`default_nettype none
module tb_charger_thermal_monitor_i2c_port;
  localparam logic [7:0] RA [8] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h03, 8'h04, 8'h06};
  localparam logic [7:0] RV [8] = '{8'h7c, 8'h6d, 8'h38, 8'h27, 8'hc0, 8'h04, 8'h00, 8'h00};
  localparam logic [7:0] PM [4] = '{8'h02, 8'h06, 8'h03, 8'h07};
  localparam logic [7:0] WA = {ctm_pkg::TARGET_ADDR, 1'b0};
  logic clk, srst, scl, sda, sda_low, sda_o, sda_oe_n, pb, vld, avld;
  logic pin_o, pin_oe_n, int_o, int_oe_n, bias, abias, susp, halt, dis, red;
  logic [2:0] sup;
  logic [2:0] n;
  logic [15:0] res, ares;
  logic [7:0] fcc, code, rvc, rd, rv, av;
  logic [31:0] rnd;
  int error_cnt, num_checks, cyc;
  assign sda = ~sda_low & (sda_oe_n | sda_o);
  ctm_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ctm_top #(.WINDOW_CYCLES(20), .PERIOD_CYCLES(100)) u_dut (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .in_above_lockout(sup[0]), .in_above_sleep(sup[1]), .in_below_ovp(sup[2]),
    .pushbutton_input(pb), .status_pin_o(pin_o), .status_pin_oe_n(pin_oe_n), .int_o(int_o),
    .int_oe_n(int_oe_n), .ts_bias_en(bias), .aux_bias_en(abias), .ts_result(res),
    .ts_result_valid(vld), .aux_result(ares), .aux_result_valid(avld),
    .fast_charge_current(fcc), .charge_current_code(code), .charge_suspend(susp),
    .safety_timer_halt(halt), .charge_disable(dis), .battery_regulation_reduce(red),
    .reduced_voltage_code(rvc));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] scaled(input logic [7:0] c, input logic [2:0] k);
    return 8'((11'(c) * (11'd8 - 11'(k))) >> 3);
  endfunction : scaled
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chk1
  task automatic w(input int k);
    repeat (k) @(negedge clk);
  endtask : w
  task automatic wb(input logic [7:0] b, input logic ack_n);
    logic a;
    u_host.wr(b, a);
    chk1(a, ack_n);
  endtask : wb
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    u_host.start();
    wb(WA, 1'b0);
    wb(a, 1'b0);
    wb(d, 1'b0);
    u_host.stop();
  endtask : reg_wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.start();
    wb(WA, 1'b0);
    wb(a, 1'b0);
    u_host.start();
    wb(WA | 8'h01, 1'b0);
    u_host.rd(1'b1, rd);
    u_host.stop();
    chk(rd, e);
  endtask : rd_chk
  task automatic feed(input logic aux, input logic [7:0] v);
    for (int k = 0; k < 400 && (aux ? abias : bias) !== 1'b1; k++) @(negedge clk);
    rnd = lfsr(rnd);
    res = aux ? res : {v, rnd[7:0]};
    ares = aux ? {v, rnd[7:0]} : ares;
    vld = ~aux;
    avld = aux;
    w(1);
    vld = 1'b0;
    avld = 1'b0;
    w(4);
  endtask : feed
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    srst = 1'b1;
    sup = 3'h7;
    pb = 1'b1;
    vld = 1'b0;
    avld = 1'b0;
    res = 16'h0000;
    ares = 16'h0000;
    rnd = lfsr(32'hb801);
    fcc = rnd[7:0];
    w(10);
    srst = 1'b0;
    w(10);
    chk1(pin_oe_n, 1'b0);
    for (int i = 0; i < 8; i++) rd_chk(RA[i], RV[i]);
    rd_chk(8'h3f, 8'hff);
    u_host.start();
    wb(WA ^ 8'h02, 1'b1);
    u_host.stop();
    rv = rnd[15:8];
    reg_wr(8'h05, rv);
    chk(rvc, rv);
    for (int i = 0; i < 3; i++) begin
      sup[i] = 1'b0;
      w(10);
      chk1(pin_oe_n, 1'b1);
      sup[i] = 1'b1;
      w(10);
      chk1(pin_oe_n, 1'b0);
    end
    rd_chk(8'h05, rv);
    reg_wr(8'h03, 8'h01);
    pb = 1'b0;
    w(10);
    chk1(pin_oe_n, 1'b0);
    pb = 1'b1;
    w(10);
    chk1(pin_oe_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h03, PM[i]);
      w(10);
      chk1(pin_oe_n, PM[i][2]);
    end
    reg_wr(8'h03, 8'h04);
    n = rnd[18:16];
    reg_wr(8'h04, {3'h0, n, 2'h0});
    feed(1'b0, 8'h50);
    chk(code, fcc);
    feed(1'b0, 8'h75);
    chk(code, scaled(fcc, n));
    chk1(int_oe_n, 1'b0);
    reg_wr(8'h04, 8'h1c);
    fcc = 8'h0c;
    w(3);
    chk(code, 8'h01);
    feed(1'b0, 8'h20);
    chk1(susp, 1'b1);
    chk1(halt, 1'b1);
    rd_chk(8'h00, 8'h05);
    rd_chk(8'h00, 8'h00);
    feed(1'b0, 8'h30);
    chk1(red, 1'b1);
    feed(1'b0, 8'h90);
    chk1(susp, 1'b1);
    feed(1'b0, 8'hd0);
    chk1(dis, 1'b1);
    rd_chk(8'h01, 8'hd0);
    reg_wr(8'h04, 8'h1d);
    feed(1'b0, 8'h50);
    feed(1'b0, 8'h75);
    chk(code, fcc);
    feed(1'b0, 8'h20);
    chk1(susp, 1'b1);
    rd_chk(8'h00, 8'h1f);
    reg_wr(8'h04, 8'h02);
    feed(1'b0, 8'h50);
    feed(1'b0, 8'h20);
    chk1(susp, 1'b0);
    chk1(int_oe_n, 1'b0);
    rd_chk(8'h00, 8'h01);
    w(2600);
    chk1(int_oe_n, 1'b1);
    reg_wr(8'h06, 8'h03);
    av = rnd[23:16];
    feed(1'b1, av);
    rd_chk(8'h02, av);
    stop_test();
  end
endmodule : tb_charger_thermal_monitor_i2c_port
`default_nettype wire
